// [common/rss_pkg.sv]
// rss_pkg: constants and types for the reset source sequencer.
// assumes one 25 MHz system clock; the low-speed oscillator arrives as a pin level.
package rss_pkg;
  // release count in low-speed oscillator clocks after power-on or monitor one
  localparam logic [5:0] RSS_RELEASE_COUNT = 6'h20;
  // cpu clock divider select after reset: low-speed osc divided by eight
  localparam logic [1:0] RSS_CPU_DIV_8 = 2'h3;
  // reset vector location, arbitrary fetch pointer for the cpu
  localparam logic [19:0] RSS_RESET_VECTOR_ADDR = 20'hFFFFC;
  // number of general purpose port pins
  localparam int RSS_PORT_PINS = 16;
  // count of reset sources
  localparam int RSS_SOURCES = 6;
  // minimum pin low time expected of the outside, microseconds
  localparam int RSS_PIN_LOW_US = 500;
  // source codes shown on the cause output
  localparam logic [2:0] RSS_CAUSE_PIN = 3'h0;
  localparam logic [2:0] RSS_CAUSE_POR = 3'h1;
  localparam logic [2:0] RSS_CAUSE_MON1 = 3'h2;
  localparam logic [2:0] RSS_CAUSE_MON2 = 3'h3;
  localparam logic [2:0] RSS_CAUSE_WDT = 3'h4;
  localparam logic [2:0] RSS_CAUSE_SW = 3'h5;
  // sequencer states
  typedef enum logic [1:0] {
    RSS_HOLD = 2'b00,
    RSS_COUNT = 2'b01,
    RSS_RUN = 2'b10
  } rss_state_t;
endpackage

// [hdl/rss_reset_source_sequencer.sv]
// rss_reset_source_sequencer: gathers six reset sources into one internal reset.
// assumes the pin, supply comparators and slow oscillator are asynchronous levels;
// watchdog and software requests come from logic on clk_in.
// ram is never touched here; the cpu clock choice and the vector are constants.
`timescale 1ns/10ps
`default_nettype none
module rss_reset_source_sequencer (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic reset_pin_n_in,            // external reset pin, low active
  input wire logic supply_above_first_in,     // supply above first_detect_threshold
  input wire logic supply_above_second_in,    // supply above second_detect_threshold
  input wire logic low_speed_osc_clock_in,    // slow oscillator as a level
  input wire logic watchdog_underflow_in,     // one-cycle pulse
  input wire logic watchdog_reset_select_bit_in,
  input wire logic software_reset_request_bit_in, // one-cycle write strobe of a 1
  input wire logic monitor_one_enable_in,     // software's monitor one enable
  input wire logic monitor_one_enable_load_in, // strobe loading monitor_one_enable_in
  input wire logic monitor_two_enable_in,
  input wire logic monitor_two_mode_select_in,
  output logic internal_reset_n_out,
  output logic [19:0] fetch_addr_out,
  output logic fetch_start_out,
  output logic [1:0] cpu_clock_div_out,
  output logic [15:0] port_dir_out,
  output logic ram_clear_out,
  output logic monitor_one_enabled_out,
  output logic cold_reset_out,
  output logic [2:0] reset_cause_out,
  output logic monitor_two_irq_out
);
  // two-flop synchronisers for asynchronous levels
  logic [3:0] sync1_q, sync1_d, sync2_q, sync2_d;
  // sequencer state and counters
  rss_pkg::rss_state_t state_q, state_d;
  logic [5:0] count_q, count_d;
  logic osc_prev_q, osc_prev_d;
  logic mon1_en_q, mon1_en_d;           // monitor one reset enable
  logic cold_q, cold_d;                 // last reset was power-on or monitor one
  logic sw_hold_q, sw_hold_d;           // latched one-shot source
  logic [2:0] cause_q, cause_d;
  logic start_q, start_d;
  logic mon2_prev_q, mon2_prev_d;
  logic irq_q, irq_d;
  // synchronised views
  logic pin_n_s, above1_s, above2_s, osc_s, osc_edge;
  logic mon1_src, mon2_src, wdt_src, sw_src, any_src, cold_src;

  assign pin_n_s = sync2_q[0];
  assign above1_s = sync2_q[1];
  assign above2_s = sync2_q[2];
  assign osc_s = sync2_q[3];
  // count only rising edges of the slow oscillator seen after synchronising
  assign osc_edge = osc_s & ~osc_prev_q;

  // source decode: power-on shares the first threshold comparator with monitor one
  always_comb
  begin
    // monitor one resets only with its enable; power-on needs none
    mon1_src = ~above1_s & mon1_en_q;
    mon2_src = ~above2_s & monitor_two_enable_in & monitor_two_mode_select_in;
    wdt_src = watchdog_underflow_in & watchdog_reset_select_bit_in;
    sw_src = software_reset_request_bit_in;
    cold_src = ~above1_s;
    // any active source keeps the reset asserted
    any_src = ~pin_n_s | cold_src | mon1_src | mon2_src | wdt_src | sw_src;
  end

  // next-state logic of the synchronisers and sequencer
  always_comb
  begin
    sync1_d = {low_speed_osc_clock_in, supply_above_second_in,
               supply_above_first_in, reset_pin_n_in};
    sync2_d = sync1_q;
    osc_prev_d = osc_s;
    state_d = state_q;
    count_d = count_q;
    cold_d = cold_q;
    cause_d = cause_q;
    mon1_en_d = mon1_en_q;
    sw_hold_d = 1'b0;
    start_d = 1'b0;
    mon2_prev_d = above2_s;
    irq_d = 1'b0;
    // interrupt mode of monitor two: pulse on a threshold crossing
    // only while running: the synchronisers wake from reset at zero, so a
    // crossing seen in hold or count is the reset itself, not the supply
    if ((state_q == rss_pkg::RSS_RUN) && monitor_two_enable_in &&
        !monitor_two_mode_select_in && (above2_s != mon2_prev_q))
    begin
      irq_d = 1'b1;
    end
    if (monitor_one_enable_load_in)
    begin
      mon1_en_d = monitor_one_enable_in;
    end
    unique case (state_q)
      rss_pkg::RSS_HOLD:
      begin
        count_d = 6'h00;
        if (cold_src || mon1_src)
        begin
          cold_d = 1'b1;
          // with monitor one still off, a low first threshold is a power-on
          cause_d = cold_src && !mon1_en_q ? rss_pkg::RSS_CAUSE_POR : rss_pkg::RSS_CAUSE_MON1;
        end
        // a cold cause is kept until its count ends, even if the pin or
        // monitor two also pull reset meanwhile
        else if (!cold_q && !pin_n_s)
        begin
          cause_d = rss_pkg::RSS_CAUSE_PIN;
        end
        else if (!cold_q && mon2_src)
        begin
          cause_d = rss_pkg::RSS_CAUSE_MON2;
        end
        if (!any_src && !sw_hold_q)
        begin
          // cold resets count the slow clock; warm ones release at once
          state_d = cold_q ? rss_pkg::RSS_COUNT : rss_pkg::RSS_RUN;
          start_d = !cold_q;
          if (cold_q)
          begin
            mon1_en_d = 1'b1;
          end
        end
      end
      rss_pkg::RSS_COUNT:
      begin
        // any source in the middle of a count starts it over from zero
        if (any_src)
        begin
          state_d = rss_pkg::RSS_HOLD;
        end
        else if (osc_edge)
        begin
          count_d = count_q + 6'h01;
          if (count_q + 6'h01 == rss_pkg::RSS_RELEASE_COUNT)
          begin
            state_d = rss_pkg::RSS_RUN;
            start_d = 1'b1;
          end
        end
      end
      rss_pkg::RSS_RUN:
      begin
        // pulse sources leave their cause here; level sources name it in hold
        if (any_src)
        begin
          state_d = rss_pkg::RSS_HOLD;
          cold_d = cold_src | mon1_src;
          sw_hold_d = 1'b1;  // stretch a pulse source through one hold cycle
          if (wdt_src)
          begin
            cause_d = rss_pkg::RSS_CAUSE_WDT;
          end
          else if (sw_src)
          begin
            cause_d = rss_pkg::RSS_CAUSE_SW;
          end
        end
      end
      default:
      begin
        state_d = rss_pkg::RSS_HOLD;
      end
    endcase
  end

  // registers only; synchronous active-low reset is a power-on start
  always_ff @(posedge clk_in)
  begin
    if (!reset_n_in)
    begin
      // sync flops start low so the supply reads as absent: a power-on
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      osc_prev_q <= 1'b0;
      state_q <= rss_pkg::RSS_HOLD;
      count_q <= 6'h00;
      cold_q <= 1'b1;
      cause_q <= rss_pkg::RSS_CAUSE_POR;
      // monitor one stays off through power-on and is switched on as the
      // cold count starts, so the power-on cause is not taken for monitor one
      mon1_en_q <= 1'b0;
      sw_hold_q <= 1'b0;
      start_q <= 1'b0;
      mon2_prev_q <= 1'b1;
      irq_q <= 1'b0;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      osc_prev_q <= osc_prev_d;
      state_q <= state_d;
      count_q <= count_d;
      cold_q <= cold_d;
      cause_q <= cause_d;
      mon1_en_q <= mon1_en_d;
      sw_hold_q <= sw_hold_d;
      start_q <= start_d;
      mon2_prev_q <= mon2_prev_d;
      irq_q <= irq_d;
    end
  end

  // outputs; ram is left alone by every reset
  assign internal_reset_n_out = (state_q == rss_pkg::RSS_RUN);
  assign fetch_addr_out = rss_pkg::RSS_RESET_VECTOR_ADDR;
  assign fetch_start_out = start_q;
  assign cpu_clock_div_out = rss_pkg::RSS_CPU_DIV_8;
  assign port_dir_out = '0;
  assign ram_clear_out = 1'b0;
  // the enable software sees, forced on as every cold count starts
  assign monitor_one_enabled_out = mon1_en_q;
  // cold means the last release waited for the slow count
  assign cold_reset_out = cold_q;
  // cause of the last reset, kept until the next one
  assign reset_cause_out = cause_q;
  // one-cycle interrupt pulse, registered
  assign monitor_two_irq_out = irq_q;
endmodule
`default_nettype wire

// [bench/rss_props.sv]
// rss_props: port checks for the reset source sequencer.
// assumes one clk_in domain; reset_n_in is synchronous, active low.
`timescale 1ns/10ps
`default_nettype none
module rss_props (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic reset_pin_n_in,
  input wire logic supply_above_first_in,
  input wire logic watchdog_underflow_in,
  input wire logic watchdog_reset_select_bit_in,
  input wire logic software_reset_request_bit_in,
  input wire logic monitor_two_enable_in,
  input wire logic monitor_two_mode_select_in,
  input wire logic internal_reset_n_out,
  input wire logic [19:0] fetch_addr_out,
  input wire logic fetch_start_out,
  input wire logic [1:0] cpu_clock_div_out,
  input wire logic [15:0] port_dir_out,
  input wire logic ram_clear_out,
  input wire logic monitor_one_enabled_out,
  input wire logic cold_reset_out,
  input wire logic monitor_two_irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // four cycles cover the two-flop sync plus the state register
  sequence pin_low_s; !reset_pin_n_in [*4]; endsequence
  sequence sup_low_s; !supply_above_first_in [*4]; endsequence
  // a pulse source is answered one cycle later and held one extra cycle
  sequence held_s; !internal_reset_n_out [*2]; endsequence
  fixed_outs_a: assert property (cpu_clock_div_out == rss_pkg::RSS_CPU_DIV_8
    && port_dir_out == 16'h0000 && !ram_clear_out) else $error("fixed outputs wrong");
  vector_fixed_a: assert property (fetch_addr_out == rss_pkg::RSS_RESET_VECTOR_ADDR)
    else $error("reset vector wrong");
  pin_hold_a: assert property (pin_low_s |-> !internal_reset_n_out)
    else $error("pin low but reset released");
  mon1_hold_a: assert property (sup_low_s |-> !internal_reset_n_out)
    else $error("supply low but reset released");
  release_fetch_a: assert property ($rose(internal_reset_n_out) |-> fetch_start_out)
    else $error("no fetch at release");
  fetch_single_a: assert property (fetch_start_out |=> !fetch_start_out)
    else $error("fetch pulse too long");
  wdt_reset_a: assert property (watchdog_underflow_in && watchdog_reset_select_bit_in
    && internal_reset_n_out |=> held_s) else $error("watchdog reset missed");
  sw_reset_a: assert property (software_reset_request_bit_in
    && internal_reset_n_out |=> held_s) else $error("software reset missed");
  mon1_on_a: assert property ($rose(internal_reset_n_out) && cold_reset_out
    |-> monitor_one_enabled_out) else $error("monitor one left off");
  irq_mode_a: assert property (monitor_two_irq_out |->
    $past(monitor_two_enable_in) && !$past(monitor_two_mode_select_in))
    else $error("monitor two interrupt outside interrupt mode");
endmodule
bind rss_reset_source_sequencer rss_props rss_props_i (.*);
`default_nettype wire

// [bench/rss_supply_model.sv]
// rss_supply_model: reset pin driver, supply comparators and slow oscillator.
// assumes clk_in from the bench; all drives change on its falling edge.
`timescale 1ns/10ps
`default_nettype none
module rss_supply_model (
  input wire logic clk_in,
  output logic pin_n_out,
  output logic sup1_out,
  output logic sup2_out,
  output logic osc_out
);
  // slow period shortened to keep cold counts brief
  localparam int OSC_P = 16;
  // supply_settle_delay in clk_in cycles, a plain guess
  localparam int SETTLE = 8;
  int ph = 0;
  initial {pin_n_out, sup1_out, sup2_out, osc_out} = 4'h1;
  // free-running oscillator, it never stops
  always @(negedge clk_in)
  begin
    ph <= (ph + 1) % OSC_P;
    osc_out <= (ph < OSC_P / 2);
  end
  // pin low during ramp, then settle plus twenty slow periods
  task automatic power_up();
    {sup1_out, sup2_out} = 2'b11;
    repeat (SETTLE + 20 * OSC_P) @(negedge clk_in);
    pin_n_out = 1'b1;
  endtask
  // supply stable: pin low twenty slow periods
  task automatic pin_pulse();
    pin_n_out = 1'b0;
    repeat (20 * OSC_P) @(negedge clk_in);
    pin_n_out = 1'b1;
  endtask
  // supply below one threshold for ten cycles
  task automatic dip(input bit first);
    if (first) sup1_out = 1'b0; else sup2_out = 1'b0;
    repeat (10) @(negedge clk_in);
    {sup1_out, sup2_out} = 2'b11;
  endtask
endmodule
`default_nettype wire

// [bench/tb_reset_source_sequencer.sv]
// tb_reset_source_sequencer: scenario tasks for the reset source sequencer.
// assumes the supply model drives the pin, supplies and slow oscillator.
`timescale 1ns/10ps
`default_nettype none
module tb_reset_source_sequencer;
  logic clk_in = 1'b0, reset_n_in = 1'b0, watchdog_underflow_in = 1'b0;
  logic watchdog_reset_select_bit_in = 1'b0, software_reset_request_bit_in = 1'b0;
  logic monitor_one_enable_in = 1'b1, monitor_one_enable_load_in = 1'b0;
  logic monitor_two_enable_in = 1'b1, monitor_two_mode_select_in = 1'b0, irq_seen = 1'b0;
  wire logic reset_pin_n_in, supply_above_first_in, supply_above_second_in;
  wire logic low_speed_osc_clock_in, internal_reset_n_out, fetch_start_out, ram_clear_out;
  wire logic monitor_one_enabled_out, cold_reset_out, monitor_two_irq_out;
  wire logic [19:0] fetch_addr_out;
  wire logic [1:0] cpu_clock_div_out;
  wire logic [15:0] port_dir_out;
  wire logic [2:0] reset_cause_out;
  int miscompares = 0, compares = 0, n;
  rss_reset_source_sequencer rss_reset_source_sequencer_i (.*);
  rss_supply_model m (.clk_in(clk_in), .pin_n_out(reset_pin_n_in),
    .sup1_out(supply_above_first_in), .sup2_out(supply_above_second_in),
    .osc_out(low_speed_osc_clock_in));
  initial forever #20 clk_in = ~clk_in;
  // catch the one-cycle interrupt pulse
  always @(negedge clk_in) if (monitor_two_irq_out === 1'b1) irq_seen <= 1'b1;
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    compares++;
    if (got !== exp) begin miscompares++; $display("ERROR %0t got %h exp %h", $time, got, exp); end
  endtask
  // bounded wait for the internal reset level, n gets the cycles spent
  task automatic wait_lvl(input logic lvl, input int lim);
    for (n = 0; n < lim && internal_reset_n_out !== lvl; n++) @(negedge clk_in);
    chk(internal_reset_n_out, lvl);
  endtask
  // cold release: 32 slow edges, then fetch at the vector
  task automatic t_cold(input logic [2:0] cause);
    wait_lvl(1'b1, 34 * m.OSC_P);
    chk(20'(n >= 31 * m.OSC_P), 20'h1);
    chk(fetch_start_out, 1'b1);
    chk(fetch_addr_out, rss_pkg::RSS_RESET_VECTOR_ADDR);
    chk(cpu_clock_div_out, rss_pkg::RSS_CPU_DIV_8);
    chk({port_dir_out, ram_clear_out}, 20'h00000);
    chk({cold_reset_out, monitor_one_enabled_out, reset_cause_out}, {2'b11, cause});
  endtask
  // warm sources: quick release, cause shown
  task automatic t_warm(input logic [2:0] cause);
    wait_lvl(1'b0, 4);
    chk(reset_cause_out, cause);
    wait_lvl(1'b1, 40 * m.OSC_P);
    chk({fetch_start_out, cold_reset_out}, 2'b10);
  endtask
  task automatic t_pulse(input bit sw, input bit sel);
    watchdog_reset_select_bit_in = sel;
    if (sw) software_reset_request_bit_in = 1'b1; else watchdog_underflow_in = 1'b1;
    @(negedge clk_in);
    {software_reset_request_bit_in, watchdog_underflow_in} = 2'b00;
    if (sw || sel) t_warm(sw ? rss_pkg::RSS_CAUSE_SW : rss_pkg::RSS_CAUSE_WDT);
    else begin repeat (6) @(negedge clk_in); chk(internal_reset_n_out, 1'b1); end
  endtask
  // monitor two: interrupt mode first, then reset mode
  task automatic t_mon2();
    m.dip(1'b0);
    repeat (6) @(negedge clk_in);
    chk({irq_seen, internal_reset_n_out}, 2'b11);
    // reset mode with the monitor switched off must not reset
    monitor_two_enable_in = 1'b0;
    monitor_two_mode_select_in = 1'b1;
    m.dip(1'b0);
    repeat (6) @(negedge clk_in);
    chk(internal_reset_n_out, 1'b1);
    monitor_two_enable_in = 1'b1;
    m.dip(1'b0);
    t_warm(rss_pkg::RSS_CAUSE_MON2);
  endtask
  task automatic t_mon1_load(input logic en);
    monitor_one_enable_in = en;
    monitor_one_enable_load_in = 1'b1;
    @(negedge clk_in);
    monitor_one_enable_load_in = 1'b0;
    @(negedge clk_in);
    chk(monitor_one_enabled_out, en);
  endtask
  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(negedge clk_in);
    reset_n_in = 1'b1;
    m.power_up();
    t_cold(rss_pkg::RSS_CAUSE_POR);
    t_mon1_load(1'b0);
    t_mon1_load(1'b1);
    m.pin_pulse();
    chk(reset_cause_out, rss_pkg::RSS_CAUSE_PIN);
    wait_lvl(1'b1, 6);
    t_pulse(1'b0, 1'b0);
    t_pulse(1'b0, 1'b1);
    t_pulse(1'b1, 1'b0);
    t_mon2();
    m.dip(1'b1);
    t_cold(rss_pkg::RSS_CAUSE_MON1);
    stop_test();
  end
  // watchdog: the whole sequence needs well under 8000 cycles
  initial
  begin
    repeat (8000) @(negedge clk_in);
    miscompares++;
    stop_test();
  end
endmodule
`default_nettype wire
